// ### src/sdc_pkg.sv
package sdc_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] SDC_OFS_REQ_PIN = 8'h94;
  localparam logic [7:0] SDC_OFS_WINDOW = 8'h98;
  localparam int SDC_ADDR_W = 8;
  localparam logic [31:0] SDC_RESET_VAL = 32'h00000000;

  // ==========================================================================
  // field layout
  // ==========================================================================
  localparam int SDC_SEL_LSB = 0;
  localparam int SDC_SEL_W = 2;
  localparam int SDC_EN_BIT = 0;
  localparam int SDC_WID_LSB = 1;
  localparam int SDC_WID_W = 2;
  localparam int SDC_EXT_BIT = 3;
  localparam int SDC_BASE_LSB = 4;
  localparam int SDC_BASE_W = 12;
  localparam int SDC_IO_ADDR_W = 32;
  localparam int SDC_IO_LOW_W = 16;

  // ==========================================================================
  // encodings
  // ==========================================================================
  typedef enum logic [1:0] {
    SDC_PIN_NONE = 2'h0,
    SDC_PIN_SPKR = 2'h1,
    SDC_PIN_IOIS16 = 2'h2,
    SDC_PIN_INPACK = 2'h3
  } sdc_pin_sel_t;

  typedef enum logic [1:0] {
    SDC_WID_8 = 2'h0,
    SDC_WID_16 = 2'h1,
    SDC_WID_RSV2 = 2'h2,
    SDC_WID_RSV3 = 2'h3
  } sdc_width_t;

  // AHB transfer types that start a transfer
  localparam logic [1:0] SDC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SDC_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] SDC_HSIZE_WORD = 3'h2;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    sdc_pin_sel_t request_pin_select;
  } sdc_req_reg_t;

  typedef struct packed {
    logic [SDC_BASE_W-1:0] dma_window_base;
    sdc_width_t transfer_width;
    logic dist_dma_decode_enable;
  } sdc_win_reg_t;

  // card-side request pins after synchronising
  typedef struct packed {
    logic spkr;
    logic iois16;
    logic inpack;
  } sdc_card_pins_t;

endpackage

// ### src/sdc_window_match.sv
`timescale 1ns/1ns
module sdc_window_match #(
  parameter int ADDR_W = 32,
  parameter int LOW_W = 16,
  parameter int BASE_LSB = 4
) (
  // programmed window
  input wire logic [LOW_W-BASE_LSB-1:0] i_base,
  input wire logic i_enable,
  // access under test
  input wire logic i_io_valid,
  input wire logic [ADDR_W-1:0] i_io_addr,
  // decision
  output logic o_hit
);

  // ==========================================================================
  // compare
  // ==========================================================================
  logic upper_zero;
  logic base_eq;

  always_comb begin
    upper_zero = (i_io_addr[ADDR_W-1:LOW_W] == '0); // R4
    base_eq = (i_io_addr[LOW_W-1:BASE_LSB] == i_base); // R5
    o_hit = i_enable && i_io_valid && upper_zero && base_eq; // R9 R11
  end

endmodule

// ### src/sdc_regs.sv
`timescale 1ns/1ns
// Function
// R1 - two-bit selector picks card DMA request pin
// R2 - request-pin register upper bits read zero
// R3 - twelve-bit writable window base, bits 15:4
// R4 - window address upper sixteen bits zero
// R5 - low four bits zero, sixteen-byte aligned
// R6 - extended addressing bit reads zero
// R7 - two-bit transfer width, 8 or 16
// R8 - never more than 16-bit card transfers
// R9 - decode enable gates window decoding
// R10 - window register bits 31:16 read zero
// R11 - claim matching I/O access when enabled
// R12 - selector zero ignores all request pins
module sdc_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // pci i/o access to decode
  input wire logic i_io_valid,
  input wire logic [31:0] i_io_addr,
  output logic o_io_claim,
  // card request pins, asynchronous
  input wire logic i_card_spkr,
  input wire logic i_card_iois16,
  input wire logic i_card_inpack,
  // dma request and configuration to the dma engine
  output logic o_dma_request,
  output logic o_xfer_16bit,
  output logic o_dma_configured
);

  // ==========================================================================
  // bus address phase capture
  // ==========================================================================
  logic ph_write;
  logic [sdc_pkg::SDC_ADDR_W-1:0] ph_addr;
  logic next_ph_write;
  logic [sdc_pkg::SDC_ADDR_W-1:0] next_ph_addr;
  logic start;

  always_comb begin
    start = i_hsel && i_hready && i_htrans[1];
    next_ph_write = start && i_hwrite;
    next_ph_addr = start ? i_haddr[sdc_pkg::SDC_ADDR_W-1:0] : ph_addr;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_write <= 1'b0;
      ph_addr <= '0;
    end else begin
      ph_write <= next_ph_write;
      ph_addr <= next_ph_addr;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  sdc_pkg::sdc_req_reg_t req_reg;
  sdc_pkg::sdc_win_reg_t win_reg;
  sdc_pkg::sdc_req_reg_t next_req_reg;
  sdc_pkg::sdc_win_reg_t next_win_reg;

  always_comb begin
    next_req_reg = req_reg;
    next_win_reg = win_reg;
    if (ph_write && (ph_addr == sdc_pkg::SDC_OFS_REQ_PIN)) begin
      // only the selector is stored; upper bits are dropped
      next_req_reg.request_pin_select = sdc_pkg::sdc_pin_sel_t'(
        i_hwdata[sdc_pkg::SDC_SEL_LSB +: sdc_pkg::SDC_SEL_W]); // R1 R2
    end
    if (ph_write && (ph_addr == sdc_pkg::SDC_OFS_WINDOW)) begin
      next_win_reg.dma_window_base =
        i_hwdata[sdc_pkg::SDC_BASE_LSB +: sdc_pkg::SDC_BASE_W]; // R3
      next_win_reg.transfer_width = sdc_pkg::sdc_width_t'(
        i_hwdata[sdc_pkg::SDC_WID_LSB +: sdc_pkg::SDC_WID_W]); // R7
      next_win_reg.dist_dma_decode_enable = i_hwdata[sdc_pkg::SDC_EN_BIT]; // R9
      // bit 3 and bits 31:16 are not stored
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_reg <= sdc_pkg::sdc_req_reg_t'(sdc_pkg::SDC_RESET_VAL[sdc_pkg::SDC_SEL_W-1:0]);
      win_reg <= sdc_pkg::sdc_win_reg_t'(
        sdc_pkg::SDC_RESET_VAL[$bits(sdc_pkg::sdc_win_reg_t)-1:0]);
    end else begin
      req_reg <= next_req_reg;
      win_reg <= next_win_reg;
    end
  end

  // ==========================================================================
  // read data
  // ==========================================================================
  logic [31:0] rd_word;
  logic [31:0] next_hrdata;
  logic [31:0] hrdata;

  always_comb begin
    rd_word = '0; // R2 R10
    // next values, so a write in its data phase is seen by a pipelined read
    case (i_haddr[sdc_pkg::SDC_ADDR_W-1:0])
      sdc_pkg::SDC_OFS_REQ_PIN: begin
        rd_word[sdc_pkg::SDC_SEL_LSB +: sdc_pkg::SDC_SEL_W] =
          next_req_reg.request_pin_select; // R2
      end
      sdc_pkg::SDC_OFS_WINDOW: begin
        rd_word[sdc_pkg::SDC_BASE_LSB +: sdc_pkg::SDC_BASE_W] =
          next_win_reg.dma_window_base; // R3
        rd_word[sdc_pkg::SDC_EXT_BIT] = 1'b0; // R6
        rd_word[sdc_pkg::SDC_WID_LSB +: sdc_pkg::SDC_WID_W] =
          next_win_reg.transfer_width; // R7
        rd_word[sdc_pkg::SDC_EN_BIT] = next_win_reg.dist_dma_decode_enable; // R9
      end
      default: begin
        rd_word = '0;
      end
    endcase
    // a register written in the previous cycle is read back current
    next_hrdata = (start && !i_hwrite) ? rd_word : hrdata;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hrdata <= '0;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // zero wait states: the slave never stalls and never errors
  assign o_hrdata = hrdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ==========================================================================
  // card pin synchronisers
  // ==========================================================================
  sdc_pkg::sdc_card_pins_t pins_meta;
  sdc_pkg::sdc_card_pins_t pins_sync;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= {i_card_spkr, i_card_iois16, i_card_inpack};
      pins_sync <= pins_meta;
    end
  end

  // ==========================================================================
  // request pin selection and window decode
  // ==========================================================================
  logic next_dma_request;
  logic dma_request;
  logic win_hit;

  always_comb begin
    case (req_reg.request_pin_select)
      sdc_pkg::SDC_PIN_SPKR: next_dma_request = pins_sync.spkr; // R1
      sdc_pkg::SDC_PIN_IOIS16: next_dma_request = pins_sync.iois16; // R1
      sdc_pkg::SDC_PIN_INPACK: next_dma_request = pins_sync.inpack; // R1
      sdc_pkg::SDC_PIN_NONE: next_dma_request = 1'b0; // R12
      default: next_dma_request = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dma_request <= 1'b0;
    end else begin
      dma_request <= next_dma_request;
    end
  end

  sdc_window_match #(
    .ADDR_W(sdc_pkg::SDC_IO_ADDR_W),
    .LOW_W(sdc_pkg::SDC_IO_LOW_W),
    .BASE_LSB(sdc_pkg::SDC_BASE_LSB)
  ) u_match (
    .i_base(win_reg.dma_window_base),
    .i_enable(win_reg.dist_dma_decode_enable),
    .i_io_valid(i_io_valid),
    .i_io_addr(i_io_addr),
    .o_hit(win_hit)
  );

  assign o_io_claim = win_hit; // R11
  assign o_dma_request = dma_request;
  // reserved widths fall back to 8-bit; 32-bit is never selectable
  assign o_xfer_16bit = (win_reg.transfer_width == sdc_pkg::SDC_WID_16); // R8
  assign o_dma_configured = (req_reg.request_pin_select != sdc_pkg::SDC_PIN_NONE);

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence s_write_win;
    i_hsel && i_hready && i_htrans[1] && i_hwrite &&
      (i_haddr[sdc_pkg::SDC_ADDR_W-1:0] == sdc_pkg::SDC_OFS_WINDOW);
  endsequence

  sequence s_read_req;
    i_hsel && i_hready && i_htrans[1] && !i_hwrite &&
      (i_haddr[sdc_pkg::SDC_ADDR_W-1:0] == sdc_pkg::SDC_OFS_REQ_PIN);
  endsequence

  sequence s_write_req;
    i_hsel && i_hready && i_htrans[1] && i_hwrite &&
      (i_haddr[sdc_pkg::SDC_ADDR_W-1:0] == sdc_pkg::SDC_OFS_REQ_PIN);
  endsequence

  sequence s_read_win;
    i_hsel && i_hready && i_htrans[1] && !i_hwrite &&
      (i_haddr[sdc_pkg::SDC_ADDR_W-1:0] == sdc_pkg::SDC_OFS_WINDOW);
  endsequence

  AST_REQ_STORED: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    s_write_req ##1 1'b1 |=> (req_reg.request_pin_select ==
      $past(i_hwdata[sdc_pkg::SDC_SEL_LSB +: sdc_pkg::SDC_SEL_W])))
    else $error("request-pin selector not stored from write data");

  AST_REQ_READBACK: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    s_read_req |=> (o_hrdata[sdc_pkg::SDC_SEL_LSB +: sdc_pkg::SDC_SEL_W] ==
      req_reg.request_pin_select))
    else $error("request-pin selector read back wrong");

  AST_WIN_READBACK: assert property (@(posedge i_clk) disable iff (i_rst) // R3 R7 R9
    s_read_win |=> (o_hrdata[sdc_pkg::SDC_IO_LOW_W-1:0] == {win_reg.dma_window_base,
      1'b0, win_reg.transfer_width, win_reg.dist_dma_decode_enable}))
    else $error("window register read back wrong");

  AST_REQ_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    s_read_req |=> (o_hrdata[31:2] == '0))
    else $error("request-pin register upper bits not zero");

  AST_BASE_STORED: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    s_write_win ##1 1'b1 |=> (win_reg.dma_window_base == $past(i_hwdata[15:4])))
    else $error("window base not stored from write data");

  AST_WIDTH_STORED: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    s_write_win ##1 1'b1 |=> (win_reg.transfer_width == $past(i_hwdata[2:1])))
    else $error("transfer width not stored from write data");

  AST_WIN_READ_ZEROS: assert property (@(posedge i_clk) disable iff (i_rst) // R10 R6
    s_read_win |=> (o_hrdata[31:16] == '0 && !o_hrdata[sdc_pkg::SDC_EXT_BIT]))
    else $error("window register reserved bits not zero");

  AST_NO_CLAIM_DISABLED: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    !win_reg.dist_dma_decode_enable |-> !o_io_claim)
    else $error("claim while decode disabled");

  AST_CLAIM_MATCH: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (win_reg.dist_dma_decode_enable && i_io_valid && i_io_addr[31:16] == '0 &&
      i_io_addr[15:4] == win_reg.dma_window_base) |-> o_io_claim)
    else $error("matching access not claimed");

  AST_HIGH_ADDR_NOCLAIM: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (i_io_addr[31:16] != '0) |-> !o_io_claim)
    else $error("claim above 64K");

  AST_CLAIM_NEEDS_VALID: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    !i_io_valid |-> !o_io_claim)
    else $error("claim without an access");

  AST_CLAIM_ALIGNED: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    o_io_claim |-> (i_io_addr[sdc_pkg::SDC_IO_LOW_W-1:sdc_pkg::SDC_BASE_LSB] ==
      win_reg.dma_window_base))
    else $error("claim outside the sixteen-byte window");

  AST_NONE_IGNORES: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    (req_reg.request_pin_select == sdc_pkg::SDC_PIN_NONE) [*2] |-> !o_dma_request)
    else $error("request raised with no pin selected");

  AST_SPKR_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (req_reg.request_pin_select == sdc_pkg::SDC_PIN_SPKR) [*4] |->
      (o_dma_request == $past(pins_sync.spkr)))
    else $error("request does not follow selected pin");

  AST_IOIS16_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (req_reg.request_pin_select == sdc_pkg::SDC_PIN_IOIS16) [*4] |->
      (o_dma_request == $past(pins_sync.iois16)))
    else $error("request does not follow the second candidate pin");

  AST_INPACK_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (req_reg.request_pin_select == sdc_pkg::SDC_PIN_INPACK) [*4] |->
      (o_dma_request == $past(pins_sync.inpack)))
    else $error("request does not follow the third candidate pin");

  AST_WIDTH_MAX16: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    s_write_win ##1 1'b1 |=> (o_xfer_16bit ==
      ($past(i_hwdata[sdc_pkg::SDC_WID_LSB +: sdc_pkg::SDC_WID_W]) == sdc_pkg::SDC_WID_16)))
    else $error("16-bit transfer not set by the 16-bit width code alone");

endmodule

// ### bench/sdc_card_model.sv
`timescale 1ns/1ns
module sdc_card_model (
  // control from the bench
  input wire logic i_clk,
  input wire logic [1:0] i_sel,
  input wire logic i_all,
  input wire logic i_level,
  // card request pins
  output logic o_spkr,
  output logic o_iois16,
  output logic o_inpack
);
  logic noise = 1'b0;

  // unselected pins chatter every cycle, so a wrong pick shows up
  always @(posedge i_clk) begin
    noise <= ~noise;
  end

  assign o_spkr = (i_all || i_sel == 2'h1) ? i_level : noise;
  assign o_iois16 = (i_all || i_sel == 2'h2) ? i_level : noise;
  assign o_inpack = (i_all || i_sel == 2'h3) ? i_level : noise;
endmodule

// ### bench/socket_dma_config_regs_tb.sv
`timescale 1ns/1ns
module socket_dma_config_regs_tb;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic i_io_valid = 1'b0;
  logic [31:0] i_io_addr = 32'h0;
  logic [1:0] pin_sel = 2'h0;
  logic pin_all = 1'b0;
  logic pin_level = 1'b0;
  wire logic spkr, iois16, inpack, claim, dreq, x16, cfg, ready, resp;
  wire logic [31:0] rdata;
  int error_cnt = 0;
  int checks_done = 0;
  // address, write data, expected read back
  logic [31:0] rows [6][3] = '{'{32'h94, 32'hFFFFFFFF, 32'h3}, '{32'h94, 32'h2, 32'h2},
    '{32'h98, 32'hFFFFFFFF, 32'hFFF7}, '{32'h98, 32'h12345A5B, 32'h5A53},
    '{32'h98, 32'h4, 32'h4}, '{32'hA0, 32'hFFFFFFFF, 32'h0}};

  always #5 i_clk = ~i_clk;

  sdc_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(sdc_pkg::SDC_HSIZE_WORD),
    .i_hwdata(i_hwdata), .i_hready(ready), .o_hrdata(rdata), .o_hreadyout(ready),
    .o_hresp(resp), .i_io_valid(i_io_valid), .i_io_addr(i_io_addr), .o_io_claim(claim),
    .i_card_spkr(spkr), .i_card_iois16(iois16), .i_card_inpack(inpack),
    .o_dma_request(dreq), .o_xfer_16bit(x16), .o_dma_configured(cfg));

  sdc_card_model card (.i_clk(i_clk), .i_sel(pin_sel), .i_all(pin_all),
    .i_level(pin_level), .o_spkr(spkr), .o_iois16(iois16), .o_inpack(inpack));

  // ==========================================================================
  // compare and bus tasks
  // ==========================================================================
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // read data is taken at the edge that ends the data phase, before any update lands
  task automatic xfer(input logic is_wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rv);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_htrans <= sdc_pkg::SDC_HTRANS_NONSEQ;
    i_haddr <= a;
    i_hwrite <= is_wr;
    do @(posedge i_clk); while (ready !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk); while (ready !== 1'b1);
    rv = rdata;
    chk1("hresp", 1'b0, resp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk32(what, exp, v);
  endtask

  task automatic io_chk(input logic v, input logic [31:0] a, input logic exp);
    @(posedge i_clk);
    i_io_valid <= v;
    i_io_addr <= a;
    @(negedge i_clk);
    chk1("io_claim", exp, claim);
  endtask

  // request must follow the chosen pin only, through the synchroniser
  task automatic pin_chk(input logic [1:0] s, input logic all, input logic exp);
    @(posedge i_clk);
    pin_sel <= s;
    pin_all <= all;
    pin_level <= 1'b1;
    repeat (4) @(posedge i_clk);
    repeat (3) begin
      @(negedge i_clk);
      chk1("dma_request", exp, dreq);
    end
    @(posedge i_clk);
    pin_level <= 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk1("dma_request_low", 1'b0, dreq);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk1("configured", 1'b0, cfg);
    chk1("xfer_16bit", 1'b0, x16);
    rd_chk("req_pin", 32'h94, 32'h0);
    rd_chk("window", 32'h98, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd_chk("table_read", rows[i][0], rows[i][2]);
    end
    $display("test register table done");
    wr(32'h98, 32'h2);
    @(negedge i_clk);
    chk1("xfer_16bit", 1'b1, x16);
    wr(32'h98, 32'h6);
    @(negedge i_clk);
    chk1("xfer_16bit", 1'b0, x16);
    $display("test width done");
    wr(32'h98, 32'h1231);
    io_chk(1'b1, 32'h1230, 1'b1);
    io_chk(1'b1, 32'h123F, 1'b1);
    io_chk(1'b1, 32'h1240, 1'b0);
    io_chk(1'b1, 32'h122F, 1'b0);
    io_chk(1'b1, 32'h11230, 1'b0);
    io_chk(1'b0, 32'h1234, 1'b0);
    wr(32'h98, 32'h1230);
    io_chk(1'b1, 32'h1234, 1'b0);
    $display("test decode done");
    wr(32'h94, 32'h0);
    pin_chk(2'h0, 1'b1, 1'b0);
    for (int s = 1; s < 4; s++) begin
      wr(32'h94, 32'(s));
      @(negedge i_clk);
      chk1("configured", 1'b1, cfg);
      pin_chk(2'(s), 1'b0, 1'b1);
    end
    $display("test request pins done");
    wr(32'h98, 32'h2);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(negedge i_clk);
    chk1("xfer_16bit_in_reset", 1'b0, x16);
    chk1("configured_in_reset", 1'b0, cfg);
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk("window_rst", 32'h98, 32'h0);
    rd_chk("req_pin_rst", 32'h94, 32'h0);
    $display("test second reset done");
    end_sim();
  end

  // the tests need under two hundred cycles; this is far beyond them
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
